/* testbench/dcri_asserts.sv */
// Concurrent checks on the two-wire link, watched beside the interface.
`timescale 1ns/1ps
module dcri_asserts
    import dcri_pkg::*;
#(
    parameter logic [1:0] STRAPS = 2'h0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sSclOut,
    input wire logic sSclOe,
    input wire logic sSdaOut,
    input wire logic sSdaOe,
    input wire logic scl,
    input wire logic sda
);
    // ============================================================
    // Byte framing seen on the wires
    logic       sclQ;
    logic       sdaQ;
    logic [3:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shiftQ;
    logic       ackEdge;
    assign ackEdge = scl && !sclQ && bitCnt == ACK_SLOT && byteCnt == 3'h0;
    // A repeated start also releases the clock once, so the count restarts on the start itself.
    always_ff @(posedge ref_clk) begin
        sclQ <= rst | scl;
        sdaQ <= rst | sda;
        if (rst || (scl && sclQ && sdaQ && !sda)) begin
            bitCnt <= 4'h0;
            byteCnt <= 3'h0;
        end else if (scl && !sclQ && bitCnt == ACK_SLOT) begin
            bitCnt <= 4'h0;
            byteCnt <= byteCnt + {2'h0, byteCnt != 3'h7};
        end else if (scl && !sclQ) begin
            bitCnt <= bitCnt + 4'h1;
            shiftQ <= {shiftQ[6:0], sda};
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence holdLow;
        sSdaOe [*8];
    endsequence
    sequence firstByteAck;
        ackEdge;
    endsequence
    AST_NO_STRETCH: assert property (!sSclOe && !sSclOut)
        else $error("device drove the clock line");
    AST_DRIVE_LOW_ONLY: assert property (sSdaOe |-> !sSdaOut && !sda)
        else $error("device drove data high");
    AST_SDA_MOVES_CLK_LOW: assert property ($changed(sSdaOe) |-> !scl)
        else $error("device moved data while clock high");
    AST_ACK_HOLD: assert property ($rose(sSdaOe) |-> holdLow)
        else $error("device released data too early");
    AST_HS_CODE_NACK: assert property (firstByteAck ##0 (shiftQ[7:3] == 5'h01) |-> sda)
        else $error("master code acknowledged");
    AST_FOREIGN_NACK: assert property (firstByteAck ##0 (shiftQ[7:3] != ADDR_BASE)
        |-> sda)
        else $error("foreign address acknowledged");
    AST_OWN_ADDR_ACK: assert property (firstByteAck ##0
        (shiftQ[7:1] == {ADDR_BASE, STRAPS}) |-> !sda)
        else $error("own address not acknowledged");
    AST_NO_EXTRA_BYTE: assert property (byteCnt > 3'h3 |-> !sSdaOe)
        else $error("device sent past the last byte");
endmodule : dcri_asserts

/* testbench/dcri_tb_top.sv */
// Bench for the channel readback link: AXI4-Lite orders, both ends joined.
`timescale 1ns/1ps
module dcri_tb_top;
    import dcri_pkg::*;
    // ============================================================
    // Signals and ends
    localparam int LIMIT = 100000;
    // Per test: high speed, flag, channel, load, straps, ext address, mode bits.
    localparam logic [11:0] TESTS [6] = '{12'h264, 12'hfa5, 12'h9e6, 12'hc27, 12'he14, 12'h928};
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rdChk = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, chanSel, loadMode, pdModeOut;
    logic [31:0] s_axi_rdata, rdOut, rnd;
    logic [13:0] words [4] = '{default: 14'h0000};
    logic [11:0] t;
    logic        powerdownFlag, nack;
    logic [31:0] expQ [$];
    int          seed = 81974;
    int          numErrors = 0;
    int          testsRun = 0;
    int          cycles = 0;
    dcri_bus_if bus ();
    dcri_master i_dcri_master (.ref_clk, .rst, .bus(bus.master), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dcri_slave i_dcri_slave (.ref_clk, .rst, .bus(bus.slave), .addrPinHi(1'b1), .addrPinLo(1'b0),
        .extAddrHi(1'b0), .extAddrLo(1'b1), .chanSel, .chanWord(words[chanSel]), .powerdownFlag,
        .loadMode, .pdModeOut);
    dcri_asserts #(.STRAPS(2'h2)) i_dcri_asserts (.ref_clk, .rst, .sSclOut(bus.sSclOut),
        .sSclOe(bus.sSclOe), .sSdaOut(bus.sSdaOut), .sSdaOe(bus.sSdaOe), .scl(bus.scl),
        .sda(bus.sda));
    initial forever #2 ref_clk = ~ref_clk;
    // ============================================================
    // Tasks
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic testDone();
        $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : testDone
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge ref_clk);
        expQ.push_back({30'h0, e});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge ref_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] a, input logic chk, input logic [31:0] e);
        @(posedge ref_clk);
        if (chk)
            expQ.push_back(e);
        rdChk <= chk;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        rdOut = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axiRead
    // ============================================================
    // Result monitor and timeout
    always @(posedge ref_clk) begin
        cycles++;
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", expQ.pop_front(), {30'h0, s_axi_bresp});
        if (s_axi_rvalid && s_axi_rready && rdChk)
            check("rdata", expQ.pop_front(), {s_axi_rresp, s_axi_rdata[29:0]});
        if (cycles == LIMIT) begin
            numErrors++;
            testDone();
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        axiWrite(8'h0c, 32'h0000_0000, RESP_DECERR);
        axiRead(8'h0c, 1'b1, 32'hc000_0000);
        $display("Test unmapped done");
        for (int i = 0; i < 6; i++) begin
            t = TESTS[i];
            rnd = $random(seed);
            words[t[9:8]] <= {t[1:0], rnd[11:0]};
            axiWrite(REG_CTRL, {21'h00_0000, t[3:2], t[5:4], t[11], t[7:6], t[10], t[9:8], 1'b1},
                RESP_OKAY);
            // Busy must be seen set before waiting for it to clear, else a late start slips by.
            do axiRead(REG_STATUS, 1'b0, rdOut); while (!rdOut[0]);
            do axiRead(REG_STATUS, 1'b0, rdOut); while (rdOut[0]);
            nack = t[5:4] != 2'h2 || t[3:2] != 2'h1;
            axiRead(REG_STATUS, 1'b1, {30'h0, nack, 1'b0});
            if (!nack) begin
                axiRead(REG_DATA, 1'b1, t[10] ? {8'h00, t[1:0], 6'h3f, rnd[11:0], 4'h0}
                    : {16'h0000, rnd[11:0], 4'h0});
                check("slave outputs", {25'h000_0000, t[9:8], t[10], t[7:6], t[1:0]},
                    {25'h000_0000, chanSel, powerdownFlag, loadMode, pdModeOut});
            end
            $display("Test %0d done", i);
        end
        testDone();
    end
endmodule : dcri_tb_top

/* verilog/dcri_bus_if.sv */
// Two-wire link between the readback master and the channel device.
`timescale 1ns/1ps
interface dcri_bus_if;
    logic mSclOut;
    logic mSclOe;
    logic mSdaOut;
    logic mSdaOe;
    logic sSclOut;
    logic sSclOe;
    logic sSdaOut;
    logic sSdaOe;
    logic scl;
    logic sda;

    // Open-drain lines with pull-ups: low only while someone drives a low.
    assign scl = ~((mSclOe & ~mSclOut) | (sSclOe & ~sSclOut));
    assign sda = ~((mSdaOe & ~mSdaOut) | (sSdaOe & ~sSdaOut));

    modport master (output mSclOut, mSclOe, mSdaOut, mSdaOe, input scl, sda);
    modport slave  (output sSclOut, sSclOe, sSdaOut, sSdaOe, input scl, sda);
endinterface : dcri_bus_if

/* verilog/dcri_master.sv */
// Far end: AXI4-Lite controlled two-wire master that runs one readback.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module dcri_master
    import dcri_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    dcri_bus_if.master       bus,
    input  wire logic  [7:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic  [3:0] s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic       [1:0] s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic  [7:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic       [1:0] s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef struct packed {
        dcri_mst_t   st;
        logic [3:0]  j;
        logic [3:0]  slot;
        logic [1:0]  ph;
        logic [7:0]  div;
        logic [23:0] rd;
        logic        nack;
        logic        sclOe;
        logic        sdaOe;
        logic [15:0] ctrl;
        logic        awHave;
        logic [7:0]  awAddr;
        logic        wHave;
        logic [15:0] wData;
        logic [1:0]  wStrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dcri_mreg_t;

    dcri_mreg_t q;
    dcri_mreg_t d;
    logic       sdaS;
    logic       hs;
    logic [3:0] stopJ;
    logic       isStart;
    logic       isRd;
    logic [7:0] wrByte;
    logic [7:0] qtr;
    logic [6:0] addr7;
    logic [15:0] m;

    dcri_sync #(.W(1)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (bus.sda),
        .syncOut (sdaS)
    );

    // ============================================================
    // Frame plan from the control register
    assign hs      = q.ctrl[F_HS];
    assign stopJ   = J_RD0 + (q.ctrl[F_PD] ? 4'h3 : 4'h2);
    assign isStart = q.j == J_HS_START || q.j == J_START || q.j == J_RSTART;
    assign isRd    = q.j >= J_RD0 && q.j < stopJ;
    assign addr7   = {ADDR_BASE, q.ctrl[F_PINS+:2]};
    assign qtr     = (hs && q.j >= J_START) ? 8'(QTR_HS_CYC - 1) : 8'(QTR_FS_CYC - 1);

    always_comb begin
        case (q.j)
            J_HS_CODE: wrByte = MASTER_CODE;
            J_ADDR_W:  wrByte = {addr7, 1'b0};
            J_CTRL:    wrByte = {q.ctrl[F_EXT+:2], q.ctrl[F_LOAD+:2], 1'b0,
                                 q.ctrl[F_CHAN+:2], q.ctrl[F_PD]};
            default:   wrByte = {addr7, 1'b1};
        endcase
    end

    assign m = {{8{q.wStrb[1]}}, {8{q.wStrb[0]}}};

    // ============================================================
    // Engine: four phases per bit, clock raised in phase 1 and lowered in 3
    always_comb begin
        d = q;
        if (q.st == M_RUN) begin
            if (q.div != 8'h00) begin
                d.div = q.div - 8'h01;
            end else begin
                d.div = qtr;
                d.ph  = q.ph + 2'h1;
                if (isStart) begin
                    case (q.ph)
                        2'h0:    d.sdaOe = 1'b0;
                        2'h1:    d.sclOe = 1'b0;
                        2'h2:    d.sdaOe = 1'b1;
                        default: begin
                            d.sclOe = 1'b1;
                            d.j     = q.j + 4'h1;
                        end
                    endcase
                end else if (q.j == stopJ) begin
                    case (q.ph)
                        2'h0:    d.sdaOe = 1'b1;
                        2'h1:    d.sclOe = 1'b0;
                        2'h2:    d.sdaOe = 1'b0;
                        default: d.st = M_IDLE;
                    endcase
                end else begin
                    case (q.ph)
                        2'h0: begin
                            if (q.slot == ACK_SLOT) begin
                                d.sdaOe = isRd && q.j != stopJ - 4'h1;
                            end else begin
                                d.sdaOe = !isRd && !wrByte[3'h7 - q.slot[2:0]];
                            end
                        end
                        2'h1: d.sclOe = 1'b0;
                        2'h2: begin
                            if (isRd && q.slot != ACK_SLOT) begin
                                d.rd = {q.rd[22:0], sdaS};
                            end else if (!isRd && q.slot == ACK_SLOT && q.j != J_HS_CODE) begin
                                d.nack = sdaS;
                            end
                        end
                        default: begin
                            d.sclOe = 1'b1;
                            d.slot  = q.slot + 4'h1;
                            if (q.slot == ACK_SLOT) begin
                                d.slot = 4'h0;
                                d.j    = q.nack ? stopJ : q.j + 4'h1;
                            end
                        end
                    endcase
                end
            end
        end

        // ========================================================
        // AXI4-Lite register slave
        if (s_axi_awvalid && s_axi_awready) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata[15:0];
            d.wStrb = s_axi_wstrb[1:0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.awHave && q.wHave) begin
            d.awHave = 1'b0;
            d.wHave  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            if (q.awAddr == REG_CTRL) begin
                d.ctrl = (q.ctrl & ~(m & CTRL_WMASK)) | (q.wData & m & CTRL_WMASK);
                if (q.wStrb[0] && q.wData[F_GO] && q.st == M_IDLE) begin
                    d.st    = M_RUN;
                    d.j     = q.wData[F_HS] ? J_HS_START : J_START;
                    d.slot  = 4'h0;
                    d.ph    = 2'h0;
                    d.div   = 8'h00;
                    d.rd    = 24'h00_0000;
                    d.nack  = 1'b0;
                end
            end else if (q.awAddr != REG_STATUS && q.awAddr != REG_DATA) begin
                d.bresp = RESP_DECERR;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL:   d.rdata = {16'h0000, q.ctrl};
                REG_STATUS: d.rdata = {30'h0000_0000, q.nack, q.st == M_RUN};
                REG_DATA:   d.rdata = {8'h00, q.rd};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q    <= '0;
            q.st <= M_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.awHave && !q.bvalid;
    assign s_axi_wready  = !q.wHave && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign bus.mSclOut   = 1'b0;
    assign bus.mSclOe    = q.sclOe;
    assign bus.mSdaOut   = 1'b0;
    assign bus.mSdaOe    = q.sdaOe;
endmodule : dcri_master

/* verilog/dcri_pkg.sv */
// Shared constants and types for the channel readback two-wire link.
// How it works
// - Write-direction address acknowledged by holding data low.
// - Control byte acknowledged; channel and flag kept.
// - Control: ext addr, load, ignored, channel, flag.
// - Master repeats start, resends address for reading.
// - Device acknowledges read address, then transmits bytes.
// - Latest control byte channel bits pick returned channel.
// - Flag clear: high byte then low byte.
// - Flag set: status, high, then low byte.
// - High byte holds data bits 11..4, MSB first.
// - Low byte: data bits 3..0, then don't-care.
// - Status byte: mode bits on top, six ones.
// - Master acknowledges all bytes but the last.
// - Master ends with stop or repeated start.
// - High-speed master code is never acknowledged.
// - After master code, repeated start at high speed.
// - Readback length same in every speed mode.
// - Mode bits select output termination in power-down.
// - Channel word: two mode bits, twelve data bits.
// - Device never holds the clock line low.
package dcri_pkg;
    // ============================================================
    // Link timing
    localparam int CLK_NS      = 4;
    localparam int QTR_FS_NS   = 625;
    localparam int QTR_HS_NS   = 75;
    localparam int QTR_FS_CYC  = (QTR_FS_NS + CLK_NS - 1) / CLK_NS;
    localparam int QTR_HS_CYC  = (QTR_HS_NS + CLK_NS - 1) / CLK_NS;
    // ============================================================
    // Frame layout
    localparam logic [4:0] ADDR_BASE   = 5'h13;
    localparam logic [7:0] MASTER_CODE = 8'h08;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam int CB_EXT_LO   = 6;
    localparam int CB_LOAD_LO  = 4;
    localparam int CB_CHAN_LO  = 1;
    localparam int CB_PD       = 0;
    localparam int W_PD_HI     = 13;
    localparam int W_PD_LO     = 12;
    localparam int W_DATA_HI   = 11;
    localparam int HI_BYTE_LSB = 4;
    localparam logic [5:0] PD_FILL  = 6'h3f;
    localparam logic [3:0] LO_FILL  = 4'h0;
    localparam logic [1:0] PM_HIZ   = 2'h0;
    localparam logic [1:0] PM_1K    = 2'h1;
    localparam logic [1:0] PM_100K  = 2'h2;
    localparam logic [1:0] K_ADDR   = 2'h0;
    localparam logic [1:0] K_CTRL   = 2'h1;
    localparam logic [1:0] K_OTHER  = 2'h2;
    // ============================================================
    // Master step numbers
    localparam logic [3:0] J_HS_START = 4'h0;
    localparam logic [3:0] J_HS_CODE  = 4'h1;
    localparam logic [3:0] J_START    = 4'h2;
    localparam logic [3:0] J_ADDR_W   = 4'h3;
    localparam logic [3:0] J_CTRL     = 4'h4;
    localparam logic [3:0] J_RSTART   = 4'h5;
    localparam logic [3:0] J_ADDR_R   = 4'h6;
    localparam logic [3:0] J_RD0      = 4'h7;
    // ============================================================
    // Controller registers
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam int F_GO   = 0;
    localparam int F_CHAN = 1;
    localparam int F_PD   = 3;
    localparam int F_LOAD = 4;
    localparam int F_HS   = 6;
    localparam int F_PINS = 7;
    localparam int F_EXT  = 9;
    localparam logic [15:0] CTRL_WMASK = 16'h07fe;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACKRX, S_TX, S_ACKTX, S_IGNORE} dcri_sst_t;
    typedef enum logic [0:0] {M_IDLE, M_RUN} dcri_mst_t;
endpackage : dcri_pkg

/* verilog/dcri_slave.sv */
// Device end: two-wire slave returning stored channel words on request.
`timescale 1ns/1ps
module dcri_slave
    import dcri_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    dcri_bus_if.slave        bus,
    input  wire logic        addrPinHi,
    input  wire logic        addrPinLo,
    input  wire logic        extAddrHi,
    input  wire logic        extAddrLo,
    output logic       [1:0] chanSel,
    input  wire logic [13:0] chanWord,
    output logic             powerdownFlag,
    output logic       [1:0] loadMode,
    output logic       [1:0] pdModeOut
);
    typedef struct packed {
        dcri_sst_t   st;
        logic [1:0]  kind;
        logic [3:0]  bitCnt;
        logic [7:0]  sh;
        logic        isRead;
        logic        goOn;
        logic [1:0]  byteIdx;
        logic        pdFlag;
        logic [1:0]  chan;
        logic [1:0]  load;
        logic [13:0] word;
        logic        sdaOe;
        logic        sclPrev;
        logic        sdaPrev;
    } dcri_sreg_t;

    dcri_sreg_t q;
    dcri_sreg_t d;
    logic [5:0] pinSync;
    logic       sclS;
    logic       sdaS;
    logic       sclRise;
    logic       sclFall;
    logic       startEv;
    logic       stopEv;
    logic       addrOk;
    logic       extOk;
    logic [1:0] nBytes;

    // ============================================================
    // Pin sampling and line events
    dcri_sync #(.W(6)) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn ({bus.scl, bus.sda, addrPinHi, addrPinLo, extAddrHi, extAddrLo}),
        .syncOut (pinSync)
    );

    assign sclS    = pinSync[5];
    assign sdaS    = pinSync[4];
    assign sclRise = sclS & ~q.sclPrev;
    assign sclFall = ~sclS & q.sclPrev;
    assign startEv = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
    assign stopEv  = sclS & q.sclPrev & ~q.sdaPrev & sdaS;
    assign addrOk  = q.sh[7:1] == {ADDR_BASE, pinSync[3:2]};
    assign extOk   = q.sh[7:CB_EXT_LO] == pinSync[1:0];
    assign nBytes  = q.pdFlag ? 2'h3 : 2'h2;

    // ============================================================
    // Outgoing byte for a position in the readback frame
    function automatic logic [7:0] txByte(
        input logic [1:0]  idx,
        input logic        pd,
        input logic [13:0] w
    );
        logic [1:0] e;
        e = pd ? idx : idx + 2'h1;
        case (e)
            2'h0:    txByte = {w[W_PD_HI:W_PD_LO], PD_FILL};
            2'h1:    txByte = w[W_DATA_HI:HI_BYTE_LSB];
            default: txByte = {w[HI_BYTE_LSB-1:0], LO_FILL};
        endcase
    endfunction : txByte

    // ============================================================
    // Bit engine: sample on clock rise, change data on clock fall
    always_comb begin
        logic [7:0] b;
        b         = 8'h00;
        d         = q;
        d.sclPrev = sclS;
        d.sdaPrev = sdaS;
        if (startEv) begin
            d.st     = S_RX;
            d.kind   = K_ADDR;
            d.bitCnt = 4'h0;
            d.sdaOe  = 1'b0;
        end else if (stopEv) begin
            d.st    = S_IDLE;
            d.sdaOe = 1'b0;
        end else begin
            case (q.st)
                S_RX: begin
                    if (sclRise && q.bitCnt != ACK_SLOT) begin
                        d.sh     = {q.sh[6:0], sdaS};
                        d.bitCnt = q.bitCnt + 4'h1;
                    end else if (sclFall && q.bitCnt == ACK_SLOT) begin
                        d.st = S_IGNORE;
                        if (q.kind == K_ADDR && addrOk) begin
                            d.st     = S_ACKRX;
                            d.sdaOe  = 1'b1;
                            d.isRead = q.sh[0];
                            d.byteIdx = 2'h0;
                            d.word   = chanWord;
                        end else if (q.kind == K_CTRL && extOk) begin
                            d.st     = S_ACKRX;
                            d.sdaOe  = 1'b1;
                            d.chan   = q.sh[CB_CHAN_LO+:2];
                            d.load   = q.sh[CB_LOAD_LO+:2];
                            d.pdFlag = q.sh[CB_PD];
                        end
                    end
                end
                S_ACKRX: begin
                    if (sclFall) begin
                        d.sdaOe  = 1'b0;
                        d.bitCnt = 4'h0;
                        d.st     = S_RX;
                        d.kind   = (q.kind == K_ADDR) ? K_CTRL : K_OTHER;
                        if (q.kind == K_ADDR && q.isRead) begin
                            b        = txByte(2'h0, q.pdFlag, q.word);
                            d.sh     = {b[6:0], 1'b0};
                            d.sdaOe  = ~b[7];
                            d.bitCnt = 4'h1;
                            d.st     = S_TX;
                        end
                    end
                end
                S_TX: begin
                    if (sclFall) begin
                        if (q.bitCnt == ACK_SLOT) begin
                            d.sdaOe = 1'b0;
                            d.goOn  = 1'b0;
                            d.st    = S_ACKTX;
                        end else begin
                            d.sdaOe  = ~q.sh[7];
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.bitCnt = q.bitCnt + 4'h1;
                        end
                    end
                end
                S_ACKTX: begin
                    if (sclRise) begin
                        d.goOn = ~sdaS && (q.byteIdx + 2'h1 < nBytes);
                        if (!d.goOn) begin
                            d.st = S_IGNORE;
                        end
                    end else if (sclFall && q.goOn) begin
                        b         = txByte(q.byteIdx + 2'h1, q.pdFlag, q.word);
                        d.byteIdx = q.byteIdx + 2'h1;
                        d.sh      = {b[6:0], 1'b0};
                        d.sdaOe   = ~b[7];
                        d.bitCnt  = 4'h1;
                        d.st      = S_TX;
                    end
                end
                default: d.sdaOe = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q         <= '0;
            q.st      <= S_IDLE;
            q.sclPrev <= 1'b1;
            q.sdaPrev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // Outputs
    assign bus.sSdaOut   = 1'b0;
    assign bus.sSdaOe    = q.sdaOe;
    assign bus.sSclOut   = 1'b0;
    assign bus.sSclOe    = 1'b0;
    assign chanSel       = q.chan;
    assign powerdownFlag = q.pdFlag;
    assign loadMode      = q.load;
    // Mode bits of the selected word; the analog stage maps them to a termination.
    assign pdModeOut     = chanWord[W_PD_HI:W_PD_LO];
endmodule : dcri_slave

/* verilog/dcri_sync.sv */
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module dcri_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1Q;

    // Reset to ones so an idle, pulled-up line is never seen as a start.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                stage1Q[i] <= 1'b1;
                syncOut[i] <= 1'b1;
            end else begin
                stage1Q[i] <= asyncIn[i];
                syncOut[i] <= stage1Q[i];
            end
        end
    end
endmodule : dcri_sync
